// *** rtl/core_pkg.sv ***
// shared constants, enumerations and field layout of the core and its bus slave
package core_pkg;
	// instruction and data widths
	localparam int unsigned instr_w = 14;
	localparam int unsigned data_w = 8;
	localparam int unsigned pc_w = 13;
	localparam int unsigned pmem_depth = 512;
	localparam int unsigned pmem_aw = 9;
	localparam int unsigned gpr_depth = 80;
	localparam int unsigned stack_depth = 8;
	localparam logic [pc_w-1:0] reset_vector = 13'h0000;
	// file register map (bank 0 only)
	localparam logic [6:0] f_indf = 7'h00;
	localparam logic [6:0] f_pcl = 7'h02;
	localparam logic [6:0] f_status = 7'h03;
	localparam logic [6:0] f_fsr = 7'h04;
	localparam logic [6:0] f_pclath = 7'h0a;
	localparam logic [6:0] gpr_first = 7'h20;
	localparam logic [6:0] gpr_last = 7'h6f;
	// status flag positions
	localparam int unsigned st_c = 0;
	localparam int unsigned st_dc = 1;
	localparam int unsigned st_z = 2;
	// instruction field positions
	localparam int unsigned ir_dest_bit = 7;
	localparam int unsigned ir_bitno_lsb = 7;
	// bus register offsets and fields
	localparam logic [7:0] reg_ctrl = 8'h00;
	localparam logic [7:0] reg_state = 8'h04;
	localparam logic [7:0] reg_pc = 8'h08;
	localparam logic [7:0] reg_prog = 8'h0c;
	localparam int unsigned ctrl_run = 0;
	localparam int unsigned ctrl_rc = 1;
	localparam int unsigned state_flags_lsb = 8;
	localparam int unsigned state_rst_bit = 11;
	localparam int unsigned prog_addr_lsb = 16;
	localparam logic [2:0] hsize_word = 3'h2;
	// quadrature phases of one instruction cycle
	typedef enum logic [1:0] {phase_one, phase_two, phase_three, phase_four} phase_e;
	// alu operations; a is the working register side, b the file or literal side
	typedef enum logic [3:0] {
		op_pass_b, op_pass_a, op_add, op_sub, op_and, op_or, op_xor,
		op_com, op_inc, op_dec, op_rr, op_rl, op_swap, op_clr
	} alu_op_e;
endpackage

// *** rtl/alu_if.sv ***
`timescale 1ns/1ns
// operand, operation and result bundle between core and alu
interface alu_if;
	logic [7:0] a;
	logic [7:0] b;
	core_pkg::alu_op_e op;
	logic cin;
	logic [7:0] y;
	logic c;
	logic dc;
	logic z;
	modport core (output a, output b, output op, output cin, input y, input c, input dc, input z);
	modport unit (input a, input b, input op, input cin, output y, output c, output dc, output z);
endinterface

// *** rtl/alu_unit.sv ***
`timescale 1ns/1ns
// 8-bit combinational alu with carry, digit carry and zero outputs
module alu_unit (
	alu_if.unit bus // operands in, result and flags out
);
	// subtraction is b minus a; carries are inverted borrows
	always_comb
	begin
		logic [8:0] s;
		logic [4:0] n;
		s = '0;
		n = '0;
		bus.y = bus.b;
		bus.c = bus.cin;
		bus.dc = 1'b0;
		case (bus.op)
			core_pkg::op_pass_b: bus.y = bus.b;
			core_pkg::op_pass_a: bus.y = bus.a;
			core_pkg::op_add:
			begin
				s = {1'b0, bus.a} + {1'b0, bus.b};
				n = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
				bus.y = s[7:0];
				bus.c = s[8];
				bus.dc = n[4];
			end
			core_pkg::op_sub:
			begin
				// two's complement add of the inverted subtrahend
				s = {1'b0, bus.b} + {1'b0, ~bus.a} + 9'h001;
				n = {1'b0, bus.b[3:0]} + {1'b0, ~bus.a[3:0]} + 5'h01;
				bus.y = s[7:0];
				bus.c = s[8];
				bus.dc = n[4];
			end
			core_pkg::op_and: bus.y = bus.a & bus.b;
			core_pkg::op_or: bus.y = bus.a | bus.b;
			core_pkg::op_xor: bus.y = bus.a ^ bus.b;
			core_pkg::op_com: bus.y = ~bus.b;
			core_pkg::op_inc: bus.y = bus.b + 8'h01;
			core_pkg::op_dec: bus.y = bus.b - 8'h01;
			core_pkg::op_rr:
			begin
				bus.y = {bus.cin, bus.b[7:1]};
				bus.c = bus.b[0];
			end
			core_pkg::op_rl:
			begin
				bus.y = {bus.b[6:0], bus.cin};
				bus.c = bus.b[7];
			end
			core_pkg::op_swap: bus.y = {bus.b[3:0], bus.b[7:4]};
			core_pkg::op_clr: bus.y = 8'h00;
			default: bus.y = bus.b;
		endcase
		bus.z = (bus.y == 8'h00);
	end
endmodule

// *** rtl/risc_core.sv ***
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
// processor core: phase sequencer, fetch/execute pipeline, file registers, program store, bus slave
// Operation
// - 14-bit instructions fetched whole each cycle over a program path apart from data.
// - fetch of the next instruction overlaps execution of the current one.
// - every instruction takes one instruction cycle; branches take longer.
// - program memory lives entirely on chip, 512 words of 14 bits.
// - special registers, program counter included, sit in the data space.
// - any operation may target any file register through any addressing mode.
// - 8-bit alu adds, subtracts, shifts and does logic between w and files.
// - arithmetic is two's complement.
// - two-operand instructions pair w with a file register or a literal.
// - single-operand instructions use w or a file register.
// - 8-bit working register has no data address.
// - instructions update carry, digit carry, zero as defined; others stay unchanged.
// - in subtraction carry and digit carry report inverted borrow out.
// - in rc mode, while the core is out of reset, a clock at a quarter of the input rate is driven out.
// - external reset is active low; the core stays reset while it is low.
// - input clock divided by four into four phases forming one instruction cycle.
// - pc increments in phase one; instruction latched in phase four, executed next.
// - operand read in phase two, destination written in phase four.
// - a pc change flushes the prefetched instruction; branch takes two cycles.
module risc_core (
	input wire logic hclk, // bus clock, also the oscillator input
	input wire logic hresetn, // asynchronous reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready, always high
	output logic hresp, // response, always okay
	output logic [31:0] hrdata, // read data
	input wire logic external_reset_n, // external core reset pin, active low
	output logic instr_rate_out // quarter-rate clock in rc mode while the core runs
);
	typedef struct packed {
		logic [1:0] rst_sync;
		core_pkg::phase_e phase;
		logic [12:0] pc;
		logic pc_go;
		logic [13:0] ir;
		logic ir_valid;
		logic [7:0] w;
		logic [7:0] opnd;
		logic [7:0] status;
		logic [7:0] fsr;
		logic [7:0] pclath;
		logic [2:0] sp;
		logic [7:0][12:0] stack;
		logic [79:0][7:0] gpr;
		logic [511:0][13:0] pmem;
		logic run;
		logic rc_mode;
		logic clkout;
		logic ahb_wr;
		logic [7:0] ahb_addr;
		logic [31:0] rdata;
	} core_s;

	core_s s_q;
	core_s s_d;
	logic core_rst;
	logic [6:0] faddr;
	logic [6:0] gidx;
	logic gpr_hit;
	logic [7:0] file_rd;
	logic [7:0] bit_mask;
	logic [12:0] jump_target;
	logic [3:0] dec_op; // raw op code, so the decode table can pack it with its flag bits
	logic use_lit, sel_mask, mask_inv, wr_f, wr_w, fz, fc, fdc;
	logic skip_clr, skip_set, skip_zero, is_goto, is_call, is_ret;
	logic exec_now, flush_now, skip_now;

	alu_if alu ();

	alu_unit u_alu (
		.bus(alu)
	);

	// core held in reset by the synchronised pin or by software
	assign core_rst = !s_q.rst_sync[1] || !s_q.run;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	assign instr_rate_out = s_q.clkout;

	// operand addressing: file 0 redirects through fsr
	assign faddr = (s_q.ir[6:0] == core_pkg::f_indf) ? s_q.fsr[6:0] : s_q.ir[6:0];
	assign gpr_hit = (faddr >= core_pkg::gpr_first) && (faddr <= core_pkg::gpr_last);
	assign gidx = faddr - core_pkg::gpr_first;
	assign bit_mask = 8'h01 << s_q.ir[core_pkg::ir_bitno_lsb +: 3];
	assign jump_target = {s_q.pclath[4:3], s_q.ir[10:0]};

	// file read mux; w is deliberately absent from this map
	always_comb
	begin
		case (faddr)
			core_pkg::f_pcl: file_rd = s_q.pc[7:0];
			core_pkg::f_status: file_rd = s_q.status;
			core_pkg::f_fsr: file_rd = s_q.fsr;
			core_pkg::f_pclath: file_rd = s_q.pclath;
			default: file_rd = gpr_hit ? s_q.gpr[gidx] : 8'h00;
		endcase
	end

	// instruction decode into alu op, destination, flag set and flow control
	always_comb
	begin
		dec_op = core_pkg::op_pass_b;
		use_lit = 1'b0;
		sel_mask = 1'b0;
		mask_inv = 1'b0;
		wr_f = 1'b0;
		wr_w = 1'b0;
		fz = 1'b0;
		fc = 1'b0;
		fdc = 1'b0;
		skip_clr = 1'b0;
		skip_set = 1'b0;
		skip_zero = 1'b0;
		is_goto = 1'b0;
		is_call = 1'b0;
		is_ret = 1'b0;
		case (s_q.ir[13:12])
			2'h0:
			begin
				// byte ops: destination bit picks file or w
				wr_f = s_q.ir[core_pkg::ir_dest_bit];
				wr_w = !s_q.ir[core_pkg::ir_dest_bit];
				case (s_q.ir[11:8])
					4'h0:
					begin
						dec_op = core_pkg::op_pass_a;
						wr_w = 1'b0;
						is_ret = !s_q.ir[core_pkg::ir_dest_bit] && (s_q.ir[7:1] == 7'h04);
					end
					4'h1: {dec_op, fz} = {core_pkg::op_clr, 1'b1};
					4'h2: {dec_op, fz, fc, fdc} = {core_pkg::op_sub, 3'h7};
					4'h3: {dec_op, fz} = {core_pkg::op_dec, 1'b1};
					4'h4: {dec_op, fz} = {core_pkg::op_or, 1'b1};
					4'h5: {dec_op, fz} = {core_pkg::op_and, 1'b1};
					4'h6: {dec_op, fz} = {core_pkg::op_xor, 1'b1};
					4'h7: {dec_op, fz, fc, fdc} = {core_pkg::op_add, 3'h7};
					4'h8: {dec_op, fz} = {core_pkg::op_pass_b, 1'b1};
					4'h9: {dec_op, fz} = {core_pkg::op_com, 1'b1};
					4'ha: {dec_op, fz} = {core_pkg::op_inc, 1'b1};
					4'hb: {dec_op, skip_zero} = {core_pkg::op_dec, 1'b1};
					4'hc: {dec_op, fc} = {core_pkg::op_rr, 1'b1};
					4'hd: {dec_op, fc} = {core_pkg::op_rl, 1'b1};
					4'he: dec_op = core_pkg::op_swap;
					4'hf: {dec_op, skip_zero} = {core_pkg::op_inc, 1'b1};
					default: dec_op = core_pkg::op_pass_b;
				endcase
			end
			2'h1:
			begin
				// bit ops reuse the alu with a one-hot mask on the w side, inverted for bit clear
				sel_mask = 1'b1;
				case (s_q.ir[11:10])
					2'h0: {dec_op, mask_inv, wr_f} = {core_pkg::op_and, 2'h3};
					2'h1: {dec_op, wr_f} = {core_pkg::op_or, 1'b1};
					2'h2: skip_clr = 1'b1;
					default: skip_set = 1'b1;
				endcase
			end
			2'h2:
			begin
				is_goto = s_q.ir[11];
				is_call = !s_q.ir[11];
			end
			default:
			begin
				use_lit = 1'b1;
				wr_w = 1'b1;
				case (s_q.ir[11:8])
					4'h4, 4'h5, 4'h6, 4'h7: is_ret = 1'b1;
					4'h8: {dec_op, fz} = {core_pkg::op_or, 1'b1};
					4'h9: {dec_op, fz} = {core_pkg::op_and, 1'b1};
					4'ha: {dec_op, fz} = {core_pkg::op_xor, 1'b1};
					4'hb: wr_w = 1'b0;
					4'hc, 4'hd: {dec_op, fz, fc, fdc} = {core_pkg::op_sub, 3'h7};
					4'he, 4'hf: {dec_op, fz, fc, fdc} = {core_pkg::op_add, 3'h7};
					default: dec_op = core_pkg::op_pass_b;
				endcase
			end
		endcase
	end

	// alu operands: w (or bit mask) on one side, file or literal on the other
	assign alu.a = sel_mask ? (mask_inv ? ~bit_mask : bit_mask) : s_q.w;
	assign alu.b = use_lit ? s_q.ir[7:0] : s_q.opnd;
	assign alu.op = core_pkg::alu_op_e'(dec_op);
	assign alu.cin = s_q.status[core_pkg::st_c];

	assign exec_now = (s_q.phase == core_pkg::phase_four) && s_q.ir_valid && !core_rst;
	assign flush_now = exec_now && (is_goto || is_call || is_ret || (wr_f && faddr == core_pkg::f_pcl));
	assign skip_now = exec_now && ((skip_clr && (s_q.opnd & bit_mask) == 8'h00)
		|| (skip_set && (s_q.opnd & bit_mask) != 8'h00) || (skip_zero && alu.z));

	// next-state: phase sequencer, pipeline, execute, bus slave
	always_comb
	begin
		s_d = s_q;
		s_d.rst_sync = {s_q.rst_sync[0], external_reset_n};
		case (s_q.phase)
			core_pkg::phase_one:
			begin
				s_d.phase = core_pkg::phase_two;
				s_d.pc_go = 1'b1;
				if (s_q.pc_go)
					s_d.pc = s_q.pc + 13'h0001;
			end
			core_pkg::phase_two:
			begin
				s_d.phase = core_pkg::phase_three;
				s_d.opnd = file_rd;
			end
			core_pkg::phase_three: s_d.phase = core_pkg::phase_four;
			core_pkg::phase_four:
			begin
				s_d.phase = core_pkg::phase_one;
				// latch the prefetched word while the current one completes
				s_d.ir = s_q.pmem[s_q.pc[core_pkg::pmem_aw-1:0]];
				s_d.ir_valid = 1'b1;
				if (exec_now)
				begin
					if (wr_w)
						s_d.w = alu.y;
					if (wr_f)
					begin
						case (faddr)
							core_pkg::f_status: s_d.status = alu.y;
							core_pkg::f_fsr: s_d.fsr = alu.y;
							core_pkg::f_pclath: s_d.pclath = alu.y;
							core_pkg::f_pcl: s_d.pc = {s_q.pclath[4:0], alu.y};
							default:
							begin
								if (gpr_hit)
									s_d.gpr[gidx] = alu.y;
							end
						endcase
					end
					// flags beat a plain write to status
					if (fz)
						s_d.status[core_pkg::st_z] = alu.z;
					if (fc)
						s_d.status[core_pkg::st_c] = alu.c;
					if (fdc)
						s_d.status[core_pkg::st_dc] = alu.dc;
					if (is_call)
					begin
						s_d.stack[s_q.sp] = s_q.pc;
						s_d.sp = s_q.sp + 3'h1;
					end
					if (is_goto || is_call)
						s_d.pc = jump_target;
					if (is_ret)
					begin
						s_d.pc = s_q.stack[s_q.sp - 3'h1];
						s_d.sp = s_q.sp - 3'h1;
					end
					// new pc: hold the next increment and drop the stale prefetch
					if (flush_now)
						s_d.pc_go = 1'b0;
					if (flush_now || skip_now)
						s_d.ir_valid = 1'b0;
				end
			end
			default: s_d.phase = core_pkg::phase_one;
		endcase
		if (core_rst)
		begin
			s_d.phase = core_pkg::phase_one;
			s_d.pc = core_pkg::reset_vector;
			s_d.pc_go = 1'b0;
			s_d.ir_valid = 1'b0;
			s_d.sp = 3'h0;
		end
		// quarter-rate output, high in phases three and four
		s_d.clkout = s_q.rc_mode && !core_rst
			&& (s_d.phase == core_pkg::phase_three || s_d.phase == core_pkg::phase_four);
		// bus data phase: writes land one cycle after the address phase
		s_d.ahb_wr = 1'b0;
		if (s_q.ahb_wr)
		begin
			case (s_q.ahb_addr)
				core_pkg::reg_ctrl:
				begin
					s_d.run = hwdata[core_pkg::ctrl_run];
					s_d.rc_mode = hwdata[core_pkg::ctrl_rc];
				end
				core_pkg::reg_prog: s_d.pmem[hwdata[core_pkg::prog_addr_lsb +: core_pkg::pmem_aw]] =
					hwdata[core_pkg::instr_w-1:0];
				default: s_d.ahb_wr = 1'b0;
			endcase
		end
		// bus address phase; read data is prepared now so there is no wait state
		if (hsel && hready && htrans[1])
		begin
			s_d.ahb_addr = haddr[7:0];
			s_d.ahb_wr = hwrite && (hsize == core_pkg::hsize_word);
			if (!hwrite)
			begin
				case (haddr[7:0])
					core_pkg::reg_ctrl: s_d.rdata = {30'h0, s_q.rc_mode, s_q.run};
					core_pkg::reg_state: s_d.rdata = {20'h0, core_rst, s_q.status[core_pkg::st_z],
						s_q.status[core_pkg::st_dc], s_q.status[core_pkg::st_c], s_q.w};
					core_pkg::reg_pc: s_d.rdata = {19'h0, s_q.pc};
					default: s_d.rdata = 32'h0;
				endcase
			end
		end
	end

	// single state register; reset clears everything, which also holds the core
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence branch_exec_s;
		flush_now;
	endsequence
	sequence flushed_cycle_s;
		(!s_q.ir_valid)[*4] ##1 s_q.ir_valid;
	endsequence

	phase_wrap_a: assert property ((s_q.phase == core_pkg::phase_four && !core_rst) |=>
		s_q.phase == core_pkg::phase_one)
		else $error("phase four not followed by phase one");
	pc_phase_a: assert property (!$stable(s_q.pc) |-> ($past(s_q.phase) == core_pkg::phase_one
		|| $past(s_q.phase) == core_pkg::phase_four || $past(core_rst)))
		else $error("program counter moved outside phase one or four");
	ir_latch_a: assert property (!$stable(s_q.ir) |-> $past(s_q.phase) == core_pkg::phase_four)
		else $error("instruction latch changed outside phase four");
	operand_read_a: assert property (!$stable(s_q.opnd) |-> $past(s_q.phase) == core_pkg::phase_two)
		else $error("operand read outside phase two");
	w_write_a: assert property (!$stable(s_q.w) |-> $past(exec_now) && $past(wr_w))
		else $error("working register changed without a w destination");
	branch_flush_a: assert property (disable iff (!hresetn || core_rst)
		branch_exec_s |=> flushed_cycle_s)
		else $error("branch did not flush exactly one cycle");
	zero_flag_a: assert property ((exec_now && fz) |=>
		s_q.status[core_pkg::st_z] == ($past(alu.y) == 8'h00))
		else $error("zero flag does not match result");
	sub_borrow_a: assert property ((exec_now && fc && dec_op == core_pkg::op_sub) |=>
		s_q.status[core_pkg::st_c] == ($past(alu.b) >= $past(alu.a)))
		else $error("carry is not the inverted borrow");
	rate_out_a: assert property (disable iff (!hresetn || core_rst || !s_q.rc_mode)
		$rose(instr_rate_out) |-> ##4 $rose(instr_rate_out))
		else $error("rate output not a quarter of the clock");
	pin_reset_a: assert property ((!external_reset_n)[*3] |=>
		(s_q.pc == core_pkg::reset_vector && !s_q.ir_valid))
		else $error("core not reset while pin low");
endmodule

// *** verification/ahb_host_model.sv ***
// register bus master model issuing single word transfers
`timescale 1ns/1ns
module ahb_host_model (
	input wire logic hclk, // bus clock
	input wire logic hready, // bus ready from the slave
	input wire logic [31:0] hrdata, // read data from the slave
	output logic [31:0] haddr, // byte address
	output logic [1:0] htrans, // transfer type
	output logic hwrite, // write when high
	output logic [2:0] hsize, // transfer size
	output logic [31:0] hwdata // write data
);
	// idle bus from time zero
	initial
	begin
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = core_pkg::hsize_word;
		hwdata = 32'h0;
	end

	// address phase held until ready is seen high at an edge
	task automatic addr_phase(input logic [31:0] a, input logic w);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= core_pkg::hsize_word;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
	endtask

	// data phase held until ready; write data then inverted so stale data never looks valid
	task automatic write_word(input logic [31:0] a, input logic [31:0] d);
		addr_phase(a, 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		hwdata <= ~d;
	endtask

	// read data taken at the edge that ends the data phase
	task automatic read_word(input logic [31:0] a, output logic [31:0] d);
		addr_phase(a, 1'b0);
		htrans <= 2'h0;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		d = hrdata;
	endtask
endmodule

// *** verification/risc_core_alu_pipeline_tb_top.sv ***
// self-checking bench for the core: alu, flags, pipeline timing, clock out and resets
`timescale 1ns/1ns
module risc_core_alu_pipeline_tb_top;
	logic hclk;
	logic hresetn;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic external_reset_n;
	logic instr_rate_out;
	int n_fail;
	int checks;
	int cycles;
	// literal alu cases: start w, instruction, expected w, expected {z, dc, c}; flags carry over
	localparam logic [32:0] alu_cases [9] = '{
		{8'h0f, 14'h3e01, 8'h10, 3'h2},
		{8'hff, 14'h3e01, 8'h00, 3'h7},
		{8'h06, 14'h3c05, 8'hff, 3'h0},
		{8'h01, 14'h3c10, 8'h0f, 3'h1},
		{8'h05, 14'h3c05, 8'h00, 3'h7},
		{8'hf0, 14'h390f, 8'h00, 3'h7},
		{8'hf0, 14'h380f, 8'hff, 3'h3},
		{8'hff, 14'h3aff, 8'h00, 3'h7},
		{8'h7f, 14'h3e01, 8'h80, 3'h2}
	};

	risc_core dut_u (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(1'b1),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.external_reset_n(external_reset_n),
		.instr_rate_out(instr_rate_out)
	);

	ahb_host_model host_u (
		.hclk(hclk),
		.hready(hreadyout),
		.hrdata(hrdata),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata)
	);

	// 100 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// hang guard: the whole run needs about 1300 cycles
	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_fail = n_fail + 1;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks = checks + 1;
		if (got !== exp)
		begin
			n_fail = n_fail + 1;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_range(input logic [31:0] got, input int lo, input int hi, input string what);
		checks = checks + 1;
		if ((^got === 1'bx) || got < lo || got > hi)
		begin
			n_fail = n_fail + 1;
			$display("ERROR at %0t: %s got %0d outside %0d..%0d", $time, what, got, lo, hi);
		end
	endtask

	// load words from address 0 with the core held, release it, let the program settle
	task automatic run_prog(input logic [13:0] words[$]);
		host_u.write_word({24'h0, core_pkg::reg_ctrl}, 32'h0);
		for (int i = 0; i < words.size(); i++)
			host_u.write_word({24'h0, core_pkg::reg_prog}, {7'h0, 9'(i), 2'h0, words[i]});
		host_u.write_word({24'h0, core_pkg::reg_ctrl}, 32'h1);
		repeat (4 * (words.size() + 3)) @(posedge hclk);
	endtask

	task automatic read_reg(input logic [7:0] off, output logic [31:0] d);
		host_u.read_word({24'h0, off}, d);
	endtask

	// reset values, unmapped and read-only places
	task automatic test_reset_regs();
		logic [31:0] d;
		read_reg(core_pkg::reg_ctrl, d);
		chk_word(d, 32'h0, "ctrl after reset");
		read_reg(core_pkg::reg_state, d);
		chk_word(d, 32'h800, "state after reset");
		read_reg(core_pkg::reg_pc, d);
		chk_word(d, 32'h0, "pc after reset");
		read_reg(8'h10, d);
		chk_word(d, 32'h0, "unmapped read");
		host_u.write_word({24'h0, core_pkg::reg_state}, 32'h0000_07ff);
		read_reg(core_pkg::reg_state, d);
		chk_word(d, 32'h800, "state write ignored");
		chk_word({31'h0, instr_rate_out}, 32'h0, "clock out idle");
		chk_word({30'h0, hreadyout, hresp}, 32'h2, "ready high, response okay");
	endtask

	// literal operations with w: add, subtract as borrow, logic, flag keep
	task automatic test_literal_alu();
		logic [31:0] d;
		logic [32:0] c;
		for (int i = 0; i < 9; i++)
		begin
			c = alu_cases[i];
			run_prog({14'h3000 | {6'h0, c[32:25]}, c[24:11], 14'h2802});
			read_reg(core_pkg::reg_state, d);
			chk_word(d, {21'h0, c[2:0], c[10:3]}, "literal alu");
		end
	endtask

	// file operands: direct subtract, indirect write, swap into w
	task automatic test_file_ops();
		logic [31:0] d;
		run_prog({14'h303c, 14'h00a1, 14'h3040, 14'h0221, 14'h2804});
		read_reg(core_pkg::reg_state, d);
		chk_word(d, 32'h2fc, "file subtract");
		run_prog({14'h3022, 14'h0084, 14'h305a, 14'h0080, 14'h0103, 14'h0822, 14'h0e22, 14'h2807});
		read_reg(core_pkg::reg_state, d);
		chk_word(d, 32'h2a5, "indirect then swap");
	endtask

	// call and return, a skip that ends a count-down loop, then a literal add
	task automatic test_flow();
		logic [31:0] d;
		run_prog({14'h3005, 14'h00a0, 14'h2007, 14'h0ba0, 14'h2803, 14'h3e10, 14'h2806, 14'h3403});
		repeat (64) @(posedge hclk);
		read_reg(core_pkg::reg_state, d);
		chk_word(d, 32'h13, "call, return and skip");
	endtask

	// add-then-jump loop: 3 instruction cycles of 4 clocks per turn when the jump flushes
	task automatic test_branch_timing();
		logic [31:0] d;
		run_prog({14'h3000, 14'h3e01, 14'h2801});
		repeat (588) @(posedge hclk);
		host_u.write_word({24'h0, core_pkg::reg_ctrl}, 32'h0);
		read_reg(core_pkg::reg_state, d);
		chk_range({24'h0, d[7:0]}, 48, 51, "loop count");
		read_reg(core_pkg::reg_pc, d);
		chk_word(d, 32'h0, "pc cleared by hold");
	endtask

	// quarter-rate clock out only with rc mode and a running core
	task automatic sample_out(input logic [31:0] ctrl, output logic [7:0] s);
		host_u.write_word({24'h0, core_pkg::reg_ctrl}, ctrl);
		repeat (8) @(posedge hclk);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge hclk);
			s[i] = instr_rate_out;
		end
	endtask

	task automatic test_rate_out();
		logic [7:0] s;
		logic ok;
		sample_out(32'h3, s);
		ok = (s[3:0] == 4'h3) || (s[3:0] == 4'h6) || (s[3:0] == 4'hc) || (s[3:0] == 4'h9);
		chk_word({24'h0, s}, {24'h0, s[3:0], s[3:0]}, "clock out period");
		chk_word({31'h0, ok}, 32'h1, "clock out duty");
		sample_out(32'h2, s);
		chk_word({24'h0, s}, 32'h0, "clock out with core held");
		sample_out(32'h1, s);
		chk_word({24'h0, s}, 32'h0, "clock out with rc off");
	endtask

	// external pin holds the core in reset while low
	task automatic test_ext_reset();
		logic [31:0] d;
		external_reset_n <= 1'b0;
		repeat (4) @(posedge hclk);
		read_reg(core_pkg::reg_state, d);
		chk_word({31'h0, d[core_pkg::state_rst_bit]}, 32'h1, "pin reset seen");
		read_reg(core_pkg::reg_pc, d);
		chk_word(d, 32'h0, "pc under pin reset");
		external_reset_n <= 1'b1;
		repeat (4) @(posedge hclk);
		read_reg(core_pkg::reg_state, d);
		chk_word({31'h0, d[core_pkg::state_rst_bit]}, 32'h0, "pin reset released");
	endtask

	// main sequence
	initial
	begin
		n_fail = 0;
		checks = 0;
		cycles = 0;
		hresetn = 1'b0;
		external_reset_n = 1'b1;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		test_reset_regs();
		test_literal_alu();
		test_file_ops();
		test_flow();
		test_branch_timing();
		test_rate_out();
		test_ext_reset();
		report_and_stop();
	end
endmodule
